//--- verilog/fgg_fine_gain_gci.sv
// fine gain trim registers and gci time-slot data path, top module
module fgg_fine_gain_gci (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic gci_clk_in,
   input wire logic gci_sync_in,
   input wire logic gci_rx_data_in,
   output logic gci_tx_data_out,
   output logic gci_tx_data_oe_out,
   input wire logic [15:0] tx_sample_in,
   input wire logic tx_sample_valid_in,
   output logic [15:0] rx_sample_out,
   output logic rx_sample_valid_out
);

   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      logic [7:0] tx_fine_gain;
      logic [7:0] rx_fine_gain;
      logic [7:0] gci_format_control;
      logic [7:0] rdata;
      logic [2:0] clk_sync;
      logic [2:0] sync_sync;
      logic [1:0] din_sync;
      fgg_pkg::fgg_state_e state;
      logic [4:0] bit_cnt;
      logic [15:0] tx_word;
      logic [15:0] tx_shift;
      logic [15:0] rx_shift;
      logic [1:0] slot_drive;
      logic txd;
      logic txoe;
      logic rx_done;
      logic [15:0] rx_sample;
      logic rx_valid;
   } fgg_state_s;

   fgg_state_s state_reg;
   fgg_state_s state_next;

   // ************************************************
   // field views
   // ************************************************
   logic tx_direction;
   logic [3:0] tx_magnitude;
   logic rx_direction;
   logic [3:0] rx_magnitude;
   logic [1:0] format_select;
   logic first_enable;
   logic second_enable;
   logic is_lin16;
   logic drive_first;
   logic drive_second;
   logic link_rise;
   logic link_fall;
   logic sync_rise;

   assign tx_direction = state_reg.tx_fine_gain[fgg_pkg::FINE_DIRECTION_BIT];
   assign tx_magnitude = state_reg.tx_fine_gain[fgg_pkg::FINE_MAGNITUDE_MSB:fgg_pkg::FINE_MAGNITUDE_LSB];
   assign rx_direction = state_reg.rx_fine_gain[fgg_pkg::FINE_DIRECTION_BIT];
   assign rx_magnitude = state_reg.rx_fine_gain[fgg_pkg::FINE_MAGNITUDE_MSB:fgg_pkg::FINE_MAGNITUDE_LSB];
   assign format_select =
      state_reg.gci_format_control[fgg_pkg::GCI_FORMAT_SELECT_MSB:fgg_pkg::GCI_FORMAT_SELECT_LSB];
   assign first_enable = state_reg.gci_format_control[fgg_pkg::FIRST_CHANNEL_ENABLE_BIT];
   assign second_enable = state_reg.gci_format_control[fgg_pkg::SECOND_CHANNEL_ENABLE_BIT];
   assign is_lin16 = (format_select == fgg_pkg::FGG_FMT_LIN16);

   // slot ownership: in the 8-bit formats one slot carries the byte,
   // the first one when it is enabled, else the second one
   // second slot gated
   assign drive_first = first_enable;
   assign drive_second = second_enable && (is_lin16 || !first_enable);

   // edges seen only from the second and third stages, never the first
   assign link_rise = state_reg.clk_sync[1] && !state_reg.clk_sync[2];
   assign link_fall = !state_reg.clk_sync[1] && state_reg.clk_sync[2];
   assign sync_rise = state_reg.sync_sync[1] && !state_reg.sync_sync[2];

   // ************************************************
   // gain stages and slot coding
   // ************************************************
   logic [15:0] tx_trimmed;
   logic [15:0] rx_decoded;
   logic [15:0] rx_trimmed;
   logic [7:0] tx_first_byte;
   logic [7:0] tx_second_byte;

   fgg_fine_gain u_tx_gain (
      .sample_in(tx_sample_in),
      .direction_in(tx_direction),
      .magnitude_in(tx_magnitude),
      .sample_out(tx_trimmed)
   );

   fgg_fine_gain u_rx_gain (
      .sample_in(rx_decoded),
      .direction_in(rx_direction),
      .magnitude_in(rx_magnitude),
      .sample_out(rx_trimmed)
   );

   // coding follows the live register, so format changes take effect per frame
   fgg_gci_codec u_codec (
      .format_in(format_select),
      .first_enable_in(first_enable),
      .second_enable_in(second_enable),
      .tx_sample_in(state_reg.tx_word),
      .tx_first_out(tx_first_byte),
      .tx_second_out(tx_second_byte),
      .rx_first_in(state_reg.rx_shift[15:8]),
      .rx_second_in(state_reg.rx_shift[7:0]),
      .rx_sample_out(rx_decoded)
   );

   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      state_next = state_reg;
      state_next.rx_valid = 1'b0;
      state_next.rx_done = 1'b0;

      // pin synchronisers, two stages plus one history stage for edges
      state_next.clk_sync = {state_reg.clk_sync[1:0], gci_clk_in};
      state_next.sync_sync = {state_reg.sync_sync[1:0], gci_sync_in};
      state_next.din_sync = {state_reg.din_sync[0], gci_rx_data_in};

      // register writes, masked so reserved bits stay zero
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            fgg_pkg::TX_FINE_GAIN_OFFSET: begin
               state_next.tx_fine_gain = reg_wdata_in & fgg_pkg::FINE_GAIN_MASK;
            end
            fgg_pkg::RX_FINE_GAIN_OFFSET: begin
               state_next.rx_fine_gain = reg_wdata_in & fgg_pkg::FINE_GAIN_MASK;
            end
            fgg_pkg::GCI_FORMAT_CONTROL_OFFSET: begin
               state_next.gci_format_control = reg_wdata_in & fgg_pkg::GCI_FORMAT_CONTROL_MASK;
            end
            default: begin
            end
         endcase
      end

      // register reads, answered on the next edge; unmapped reads zero
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            fgg_pkg::TX_FINE_GAIN_OFFSET: begin
               state_next.rdata = state_reg.tx_fine_gain;
            end
            fgg_pkg::RX_FINE_GAIN_OFFSET: begin
               state_next.rdata = state_reg.rx_fine_gain;
            end
            fgg_pkg::GCI_FORMAT_CONTROL_OFFSET: begin
               state_next.rdata = state_reg.gci_format_control;
            end
            default: begin
               state_next.rdata = 8'h00;
            end
         endcase
      end

      // codec sample captured already trimmed; newest sample wins
      if (tx_sample_valid_in) begin
         state_next.tx_word = tx_trimmed;
      end

      // received frame: decode, trim and hand to the codec side
      if (state_reg.rx_done) begin
         state_next.rx_sample = rx_trimmed;
         state_next.rx_valid = 1'b1;
      end

      // frame engine; a frame sync always restarts the frame
      unique case (state_reg.state)
         fgg_pkg::FGG_IDLE: begin
            state_next.txoe = 1'b0;
         end
         fgg_pkg::FGG_FRAME: begin
            if (link_rise) begin
               // launch: first slot then second slot, msb first
               state_next.txd = state_reg.tx_shift[15];
               state_next.tx_shift = {state_reg.tx_shift[14:0], 1'b0};
               state_next.txoe = (state_reg.bit_cnt < fgg_pkg::SLOT_BITS) ?
                  state_reg.slot_drive[0] : state_reg.slot_drive[1];
            end
            if (link_fall) begin
               // capture from the second synchroniser stage only
               state_next.rx_shift = {state_reg.rx_shift[14:0], state_reg.din_sync[1]};
               state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
               if (state_reg.bit_cnt == fgg_pkg::FRAME_LAST_BIT) begin
                  state_next.state = fgg_pkg::FGG_IDLE;
                  state_next.txoe = 1'b0;
                  // nothing delivered when both slots are off
                  state_next.rx_done = state_reg.slot_drive[0] || state_reg.slot_drive[1];
               end
            end
         end
      endcase

      if (sync_rise) begin
         state_next.state = fgg_pkg::FGG_FRAME;
         state_next.bit_cnt = 5'h00;
         state_next.txoe = 1'b0;
         state_next.rx_shift = 16'h0000;
         state_next.tx_shift = {tx_first_byte, tx_second_byte};
         state_next.slot_drive = {drive_second, drive_first};
      end
   end

   // ************************************************
   // registers
   // ************************************************
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_reg <= '0;
         state_reg.tx_fine_gain <= fgg_pkg::TX_FINE_GAIN_RESET;
         state_reg.rx_fine_gain <= fgg_pkg::RX_FINE_GAIN_RESET;
         state_reg.gci_format_control <= fgg_pkg::GCI_FORMAT_CONTROL_RESET;
         state_reg.state <= fgg_pkg::FGG_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state flops
   assign reg_rdata_out = state_reg.rdata;
   assign gci_tx_data_out = state_reg.txd;
   assign gci_tx_data_oe_out = state_reg.txoe;
   assign rx_sample_out = state_reg.rx_sample;
   assign rx_sample_valid_out = state_reg.rx_valid;

endmodule

//--- shared/fgg_pkg.sv
// constants, encodings and trim tables for the fine gain trim and gci time-slot block
package fgg_pkg;

   // ************************************************
   // register map
   // ************************************************
   localparam logic [7:0] TX_FINE_GAIN_OFFSET = 8'h28;
   localparam logic [7:0] RX_FINE_GAIN_OFFSET = 8'h29;
   localparam logic [7:0] GCI_FORMAT_CONTROL_OFFSET = 8'h2A;
   localparam logic [7:0] TX_FINE_GAIN_RESET = 8'h00;
   localparam logic [7:0] RX_FINE_GAIN_RESET = 8'h00;
   localparam logic [7:0] GCI_FORMAT_CONTROL_RESET = 8'h00;
   localparam logic [7:0] FINE_GAIN_MASK = 8'h1F;
   localparam logic [7:0] GCI_FORMAT_CONTROL_MASK = 8'h0F;

   // ************************************************
   // field positions
   // ************************************************
   localparam int FINE_DIRECTION_BIT = 4;
   localparam int FINE_MAGNITUDE_MSB = 3;
   localparam int FINE_MAGNITUDE_LSB = 0;
   localparam int GCI_FORMAT_SELECT_MSB = 3;
   localparam int GCI_FORMAT_SELECT_LSB = 2;
   localparam int SECOND_CHANNEL_ENABLE_BIT = 1;
   localparam int FIRST_CHANNEL_ENABLE_BIT = 0;

   // ************************************************
   // frame timing, counted in link clock periods
   // ************************************************
   localparam logic [4:0] SLOT_BITS = 5'h08;
   localparam logic [4:0] FRAME_LAST_BIT = 5'h0F;

   typedef enum logic [1:0] {
      FGG_FMT_ALAW = 2'h0,
      FGG_FMT_MULAW = 2'h1,
      FGG_FMT_LIN8 = 2'h2,
      FGG_FMT_LIN16 = 2'h3
   } fgg_format_e;

   typedef enum logic {
      FGG_IDLE,
      FGG_FRAME
   } fgg_state_e;

   // ************************************************
   // trim coefficients, unsigned 1.16, index = magnitude
   // ************************************************
   localparam logic [15:0][16:0] FINE_GAIN_UP_TABLE = {
      17'h13042, 17'h12CC6, 17'h12955, 17'h125EE, 17'h12291, 17'h11F3D, 17'h11BF3, 17'h118B3,
      17'h1157C, 17'h1124F, 17'h10F2B, 17'h10C11, 17'h10900, 17'h105F7, 17'h102F7, 17'h10000};
   localparam logic [15:0][16:0] FINE_ATTEN_TABLE = {
      17'h0D766, 17'h0D9E4, 17'h0DC6A, 17'h0DEF8, 17'h0E18C, 17'h0E429, 17'h0E6CD, 17'h0E979,
      17'h0EC2E, 17'h0EEEA, 17'h0F1AE, 17'h0F47B, 17'h0F74F, 17'h0FA2C, 17'h0FD12, 17'h10000};

endpackage

//--- verilog/fgg_fine_gain.sv
// fine gain trim stage: 0.1 dB steps of gain or attenuation with saturation
module fgg_fine_gain (
   input wire logic signed [15:0] sample_in,
   input wire logic direction_in,
   input wire logic [3:0] magnitude_in,
   output logic signed [15:0] sample_out
);

   logic [16:0] coef;
   logic signed [33:0] product;
   logic signed [17:0] scaled;

   // table lookup, multiply, then clamp to the 16-bit range
   always_comb begin
      coef = direction_in ? fgg_pkg::FINE_ATTEN_TABLE[magnitude_in] : fgg_pkg::FINE_GAIN_UP_TABLE[magnitude_in];
      product = sample_in * $signed({1'b0, coef});
      scaled = product[33:16];
      if (magnitude_in == 4'h0) begin
         sample_out = sample_in;
      end else if (scaled > 18'sh07FFF) begin
         sample_out = 16'sh7FFF; // gain can push full scale over the top
      end else if (scaled < -18'sh08000) begin
         sample_out = -16'sh8000;
      end else begin
         sample_out = scaled[15:0];
      end
   end

endmodule

//--- verilog/fgg_gci_codec.sv
// sample coding for the gci slots: a-law, mu-law, 8-bit and 16-bit linear
module fgg_gci_codec (
   input wire logic [1:0] format_in,
   input wire logic first_enable_in,
   input wire logic second_enable_in,
   input wire logic [15:0] tx_sample_in,
   output logic [7:0] tx_first_out,
   output logic [7:0] tx_second_out,
   input wire logic [7:0] rx_first_in,
   input wire logic [7:0] rx_second_in,
   output logic [15:0] rx_sample_out
);

   function automatic logic [7:0] mu_enc(input logic [15:0] x);
      logic [16:0] m;
      logic [13:0] b;
      logic [2:0] seg;
      m = x[15] ? 17'h00000 - {x[15], x} : {1'b0, x};
      b = (m[16:2] > 15'h1FDE) ? 14'h1FDE : m[15:2];
      b = b + 14'h0021; // bias keeps the segment search simple
      seg = 3'h0;
      for (int i = 1; i < 8; i++) begin
         if (b[i + 5]) begin
            seg = 3'(i);
         end
      end
      return {~x[15], ~seg, ~4'(b >> ({1'b0, seg} + 4'h1))};
   endfunction

   function automatic logic [15:0] mu_dec(input logic [7:0] c);
      logic [7:0] u;
      logic [15:0] t;
      u = ~c;
      t = ({9'h000, u[3:0], 3'h0} + 16'h0084) << u[6:4];
      return u[7] ? 16'h0084 - t : t - 16'h0084;
   endfunction

   function automatic logic [7:0] a_enc(input logic [15:0] x);
      logic [12:0] p;
      logic [2:0] seg;
      logic [3:0] mant;
      p = x[15] ? ~x[15:3] : x[15:3];
      seg = 3'h0;
      for (int i = 1; i < 8; i++) begin
         if (p[i + 4]) begin
            seg = 3'(i);
         end
      end
      mant = (seg < 3'h2) ? p[4:1] : 4'(p >> seg);
      return {1'b0, seg, mant} ^ (x[15] ? 8'h55 : 8'hD5);
   endfunction

   function automatic logic [15:0] a_dec(input logic [7:0] c);
      logic [7:0] a;
      logic [15:0] t;
      a = c ^ 8'h55;
      t = {8'h00, a[3:0], 4'h0};
      if (a[6:4] == 3'h0) begin
         t = t + 16'h0008;
      end else begin
         t = (t + 16'h0108) << (a[6:4] - 3'h1);
      end
      return a[7] ? t : 16'h0000 - t;
   endfunction

   logic [7:0] rx_byte;

   // one byte per frame in the 8-bit formats, both bytes in 16-bit linear
   always_comb begin
      rx_byte = first_enable_in ? rx_first_in : rx_second_in;
      unique case (fgg_pkg::fgg_format_e'(format_in))
         fgg_pkg::FGG_FMT_ALAW: begin
            tx_first_out = a_enc(tx_sample_in);
            tx_second_out = tx_first_out;
            rx_sample_out = a_dec(rx_byte);
         end
         fgg_pkg::FGG_FMT_MULAW: begin
            tx_first_out = mu_enc(tx_sample_in);
            tx_second_out = tx_first_out;
            rx_sample_out = mu_dec(rx_byte);
         end
         fgg_pkg::FGG_FMT_LIN8: begin
            tx_first_out = tx_sample_in[15:8];
            tx_second_out = tx_sample_in[15:8];
            rx_sample_out = {rx_byte, 8'h00};
         end
         fgg_pkg::FGG_FMT_LIN16: begin
            tx_first_out = tx_sample_in[15:8];
            tx_second_out = tx_sample_in[7:0];
            rx_sample_out = {first_enable_in ? rx_first_in : 8'h00, second_enable_in ? rx_second_in : 8'h00};
         end
      endcase
   end

endmodule

//--- tb/fgg_checker.sv
// port-level assertions for the fine gain and gci block
module fgg_checker (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic gci_tx_data_oe_out,
   input wire logic [15:0] rx_sample_out,
   input wire logic rx_sample_valid_out
);
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [7:0] tx;
      logic [7:0] rx;
      logic [7:0] gci;
      logic [9:0] quiet;
   } fgg_shadow_s;
   fgg_shadow_s sh_reg;
   fgg_shadow_s sh_next;
   // shadow of written registers; quiet counts cycles with both slots off
   always_comb begin
      sh_next = sh_reg;
      if (reg_wr_in && reg_addr_in == 8'h28) sh_next.tx = reg_wdata_in & 8'h1F;
      if (reg_wr_in && reg_addr_in == 8'h29) sh_next.rx = reg_wdata_in & 8'h1F;
      if (reg_wr_in && reg_addr_in == 8'h2A) sh_next.gci = reg_wdata_in & 8'h0F;
      // wait about one bench frame: a frame begun before switch-off has ended by then,
      // while a frame begun after it is still on its last bits and its valid pulse
      if (sh_next.gci[1:0] != 2'h0) sh_next.quiet = 10'h000;
      else if (sh_reg.quiet != 10'h200) sh_next.quiet = sh_reg.quiet + 10'h001;
   end
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) sh_reg <= '0;
      else sh_reg <= sh_next;
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_read(logic [7:0] a);
      reg_rd_in && reg_addr_in == a;
   endsequence
   a_tx_readback: assert property (s_read(8'h28) |=> reg_rdata_out == $past(sh_reg.tx))
      else $error("tx fine gain readback wrong");
   a_rx_readback: assert property (s_read(8'h29) |=> reg_rdata_out == $past(sh_reg.rx))
      else $error("rx fine gain readback wrong");
   a_gci_readback: assert property (s_read(8'h2A) |=> reg_rdata_out == $past(sh_reg.gci))
      else $error("gci_format_control readback wrong");
   a_unmapped_zero: assert property (reg_rd_in && !(reg_addr_in inside {8'h28, 8'h29, 8'h2A})
      |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
   a_rdata_hold: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
      else $error("read data moved without read");
   a_valid_pulse: assert property (rx_sample_valid_out |=> !rx_sample_valid_out)
      else $error("receive valid longer than one cycle");
   a_rx_hold: assert property (!rx_sample_valid_out |-> $stable(rx_sample_out))
      else $error("receive sample moved without valid");
   a_quiet_oe: assert property (sh_reg.quiet == 10'h200 |-> !gci_tx_data_oe_out)
      else $error("slot driven with both channels off");
   a_quiet_valid: assert property (sh_reg.quiet == 10'h200 |-> !rx_sample_valid_out)
      else $error("receive valid with both channels off");
endmodule
bind fgg_fine_gain_gci fgg_checker i_checker (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .gci_tx_data_oe_out(gci_tx_data_oe_out), .rx_sample_out(rx_sample_out),
   .rx_sample_valid_out(rx_sample_valid_out));

//--- tb/fgg_host_model.sv
// gci host model: link clock, frame sync and serial data toward the block
module fgg_host_model (
   input wire logic tx_data_in,
   input wire logic tx_oe_in,
   output logic link_clk_out,
   output logic sync_out,
   output logic rx_data_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // link clock stands low between frames
   initial begin
      link_clk_out = 1'b0;
      sync_out = 1'b0;
      rx_data_out = 1'b1;
   end
   // sync rises with clock low, 16 bits msb first, block output taken on fall
   task automatic frame(input logic [15:0] word, output logic [15:0] got, output logic [15:0] oe_seen);
      sync_out = 1'b1;
      #80;
      for (int i = 15; i >= 0; i--) begin
         rx_data_out = word[i];
         link_clk_out = 1'b1;
         #80;
         link_clk_out = 1'b0;
         got[i] = tx_data_in;
         oe_seen[i] = tx_oe_in;
         sync_out = 1'b0;
         #80;
      end
      // released line: inverse of last bit so a stale sample cannot pass
      rx_data_out = ~rx_data_out;
      #400;
   endtask
endmodule

//--- tb/tb.sv
// self-checking bench for the fine gain trim and gci block
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] txg;
      logic [7:0] rxg;
      logic [15:0] samp;
      logic [15:0] word;
      logic [15:0] etx;
      logic [15:0] eoe;
      logic [15:0] erx;
   } fgg_row_s;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [7:0] reg_rdata_out;
   logic gci_clk_in, gci_sync_in, gci_rx_data_in, gci_tx_data_out, gci_tx_data_oe_out;
   logic [15:0] tx_sample_in = 16'h0000;
   logic tx_sample_valid_in = 1'b0;
   logic [15:0] rx_sample_out;
   logic rx_sample_valid_out;
   logic [7:0] d;
   logic [15:0] got, oe;
   int n_fail = 0;
   int checked = 0;
   int cycles = 0;
   int n_valid = 0;
   // register rows: address, write data, read back
   logic [23:0] regs [7] = '{24'h28FF1F, 24'h29FF1F, 24'h2AFF0F, 24'h28E505, 24'h2A5000, 24'h30FF00, 24'h27AA00};
   // frame rows: config, tx trim, rx trim, sample, host word, tx word, drive mask, received
   // last row leaves a nonzero sample so the mid-run reset has something to clear
   fgg_row_s rows [10] = '{
      '{8'h00, 8'h00, 8'h00, 16'h1234, 16'hABCD, 16'h0000, 16'h0000, 16'h0000},
      '{8'h0F, 8'h0F, 8'h0F, 16'h1000, 16'h1000, 16'h1304, 16'hFFFF, 16'h1304},
      '{8'h0F, 8'h1F, 8'h1F, 16'h1000, 16'h1000, 16'h0D76, 16'hFFFF, 16'h0D76},
      '{8'h0F, 8'h10, 8'h10, 16'h1000, 16'h1000, 16'h1000, 16'hFFFF, 16'h1000},
      '{8'h0D, 8'h00, 8'h00, 16'h1234, 16'hABCD, 16'h1200, 16'hFF00, 16'hAB00},
      '{8'h0E, 8'h00, 8'h00, 16'h1234, 16'hABCD, 16'h0034, 16'h00FF, 16'h00CD},
      '{8'h09, 8'h00, 8'h00, 16'h1234, 16'hABCD, 16'h1200, 16'hFF00, 16'hAB00},
      '{8'h0A, 8'h00, 8'h00, 16'h1234, 16'hABCD, 16'h0012, 16'h00FF, 16'hCD00},
      '{8'h05, 8'h00, 8'h00, 16'h0000, 16'hFFFF, 16'hFF00, 16'hFF00, 16'h0000},
      '{8'h01, 8'h00, 8'h00, 16'h0000, 16'hD5D5, 16'hD500, 16'hFF00, 16'h0008}};
   fgg_fine_gain_gci i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .gci_clk_in(gci_clk_in), .gci_sync_in(gci_sync_in), .gci_rx_data_in(gci_rx_data_in),
      .gci_tx_data_out(gci_tx_data_out), .gci_tx_data_oe_out(gci_tx_data_oe_out), .tx_sample_in(tx_sample_in),
      .tx_sample_valid_in(tx_sample_valid_in), .rx_sample_out(rx_sample_out),
      .rx_sample_valid_out(rx_sample_valid_out));
   fgg_host_model i_host (.tx_data_in(gci_tx_data_out), .tx_oe_in(gci_tx_data_oe_out),
      .link_clk_out(gci_clk_in), .sync_out(gci_sync_in), .rx_data_out(gci_rx_data_in));
   always #2.5 clk_in = ~clk_in;
   // receive pulses counted per frame on the settled edge; timeout bounds a hang
   always @(negedge clk_in) begin
      cycles++;
      if (rx_sample_valid_out === 1'b1) n_valid++;
      if (cycles == 20000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk_in);
      reg_addr_in = a;
      reg_wdata_in = v;
      reg_wr_in = 1'b1;
      @(negedge clk_in);
      reg_wr_in = 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge clk_in);
      reg_rd_in = 1'b0;
      v = reg_rdata_out;
   endtask
   task automatic complete_run();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge clk_in);
      rst_n_in = 1'b1;
      // registers come up cleared
      for (int a = 40; a < 43; a++) begin
         reg_rd(8'(a), d);
         check({8'h00, d}, 16'h0000);
      end
      for (int r = 0; r < 7; r++) begin
         reg_wr(regs[r][23:16], regs[r][15:8]);
         reg_rd(regs[r][23:16], d);
         check({8'h00, d}, {8'h00, regs[r][7:0]});
      end
      $display("register rows done");
      for (int r = 0; r < 10; r++) begin
         reg_wr(8'h2A, rows[r].cfg);
         reg_wr(8'h28, rows[r].txg);
         reg_wr(8'h29, rows[r].rxg);
         @(negedge clk_in);
         tx_sample_in = rows[r].samp;
         tx_sample_valid_in = 1'b1;
         @(negedge clk_in);
         tx_sample_valid_in = 1'b0;
         n_valid = 0;
         i_host.frame(rows[r].word, got, oe);
         check(oe, rows[r].eoe);
         check(got & rows[r].eoe, rows[r].etx);
         check(16'(n_valid), {15'h0000, rows[r].cfg[1:0] != 2'h0});
         if (rows[r].cfg[1:0] != 2'h0) check(rx_sample_out, rows[r].erx);
         $display("frame row %0d done", r);
      end
      // write and read in one cycle: read sees the old value
      @(negedge clk_in);
      reg_addr_in = 8'h28;
      reg_wdata_in = 8'hEA;
      reg_wr_in = 1'b1;
      reg_rd_in = 1'b1;
      @(negedge clk_in);
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      check({8'h00, reg_rdata_out}, 16'h0000);
      reg_rd(8'h28, d);
      check({8'h00, d}, 16'h000A);
      $display("same cycle test done");
      // second reset in mid-run clears control and receive sample
      rst_n_in = 1'b0;
      repeat (8) @(negedge clk_in);
      rst_n_in = 1'b1;
      check(rx_sample_out, 16'h0000);
      check({8'h00, reg_rdata_out}, 16'h0000);
      reg_rd(8'h2A, d);
      check({8'h00, d}, 16'h0000);
      $display("second reset test done");
      complete_run();
   end
endmodule
